// [rtl/tlps_buf2.sv]
/*
 two-entry buffer with valid and ready on both sides.
 assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module tlps_buf2 #(
	parameter int W = 8
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	logic [W-1:0] mem [2];
	logic [W-1:0] next_mem [2];
	logic rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
	logic [1:0] count, next_count;
	logic push, pop;

	assign in_ready_o = (count != 2'h2);
	assign out_valid_o = (count != 2'h0);
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		next_mem = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (push) begin
			next_mem[wr_ptr] = in_data_i;
			next_wr_ptr = ~wr_ptr;
		end
		if (pop) begin
			next_rd_ptr = ~rd_ptr;
		end
		if (push && !pop) begin
			next_count = count + 2'h1;
		end else if (pop && !push) begin
			next_count = count - 2'h1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			mem[0] <= '0;
			mem[1] <= '0;
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			mem <= next_mem;
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count <= next_count;
		end
	end
endmodule
`default_nettype wire

// [rtl/tlps_ctrl.sv]
/*
 controller for a line thermal head and its four-phase paper-feed stepper.
 assumes bytes of line data arrive msb first on a valid/ready port, and that
 the sense pins are asynchronous and already debounced outside.
*/
`timescale 1ns/100ps
`default_nettype none
module tlps_ctrl
	import tlps_pkg::*;
#(
	parameter int LINE_BITS_P = tlps_pkg::LINE_BITS,
	parameter int STROBE_CYC_P = tlps_pkg::STROBE_CYC,
	parameter int STEP_CYC_P = tlps_pkg::STEP_CYC,
	parameter int FIRST_STEP_CYC_P = tlps_pkg::FIRST_STEP_CYC,
	parameter int PAUSE_CYC_P = tlps_pkg::PAUSE_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [15:0] line_count_i,
	input wire logic two_division_i,
	input wire logic data_valid_i,
	output logic data_ready_o,
	input wire logic [tlps_pkg::BUF_W-1:0] data_i,
	input wire logic paper_sense_out_i,
	input wire logic head_down_sense_i,
	output logic serial_print_bits_o,
	output logic shift_clock_o,
	output logic line_store_o,
	output logic strobe_first_division_o,
	output logic strobe_second_division_o,
	output logic [3:0] motor_phase_o,
	output logic busy_o,
	output logic fault_o
);
	import tlps_pkg::*;

	tlps_state_type state, next_state;
	logic [CNT_W-1:0] tmr, next_tmr, step_tmr, next_step_tmr;
	logic [15:0] lines_left, next_lines_left;
	logic [1:0] phase_idx, next_phase_idx;
	logic motor_on, next_motor_on;
	logic stb_a, next_stb_a, stb_b, next_stb_b, latch, next_latch;
	logic paper_m, paper_s, head_m, head_s;
	logic inhibit;
	// serial shifter state
	logic sh_busy, next_sh_busy, sh_req;
	logic [15:0] bits_left, next_bits_left;
	logic [2:0] bit_idx, next_bit_idx;
	logic [1:0] div, next_div;
	logic sclk, next_sclk, sdat, next_sdat;
	logic buf_valid, buf_pop;
	logic [BUF_W-1:0] buf_data;

	tlps_buf2 #(.W(BUF_W)) u_buf (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(data_valid_i),
		.in_ready_o(data_ready_o),
		.in_data_i(data_i),
		.out_valid_o(buf_valid),
		.out_ready_i(buf_pop),
		.out_data_o(buf_data)
	);

	// sense pins, two flops each
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			paper_m <= 1'b1;
			paper_s <= 1'b1;
			head_m <= 1'b1;
			head_s <= 1'b1;
		end else begin
			paper_m <= paper_sense_out_i;
			paper_s <= paper_m;
			head_m <= head_down_sense_i;
			head_s <= head_m;
		end
	end
	assign inhibit = paper_s || head_s;

	// serial shifter: one bit per shift clock period, stalls on an empty buffer
	assign buf_pop = sh_busy && buf_valid && (div == 2'(SCLK_DIV - 1)) && sclk
		&& (bit_idx == 3'h0);
	always_comb begin
		next_sh_busy = sh_busy;
		next_bits_left = bits_left;
		next_bit_idx = bit_idx;
		next_div = div;
		next_sclk = sclk;
		next_sdat = sdat;
		if (sh_req && !sh_busy) begin
			next_sh_busy = 1'b1;
			next_bits_left = 16'(LINE_BITS_P);
			next_bit_idx = 3'h7;
			next_div = 2'h0;
		end else if (sh_busy && buf_valid) begin
			next_div = div + 2'h1;
			if (div == 2'h0) begin
				next_sdat = buf_data[bit_idx];
			end else if (div == 2'h1) begin
				next_sclk = 1'b1;
			end else if (div == 2'(SCLK_DIV - 1)) begin
				next_sclk = 1'b0;
				next_bit_idx = bit_idx - 3'h1;
				next_bits_left = bits_left - 16'h1;
				if (bits_left == 16'h1) begin
					next_sh_busy = 1'b0;
				end
			end
		end
	end
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sh_busy <= 1'b0;
			bits_left <= 16'h0;
			bit_idx <= 3'h7;
			div <= 2'h0;
			sclk <= 1'b0;
			sdat <= 1'b0;
		end else begin
			sh_busy <= next_sh_busy;
			bits_left <= next_bits_left;
			bit_idx <= next_bit_idx;
			div <= next_div;
			sclk <= next_sclk;
			sdat <= next_sdat;
		end
	end

	// sequencer
	always_comb begin
		next_state = state;
		next_tmr = (tmr != '0) ? tmr - CNT_W'(1) : tmr;
		next_step_tmr = (step_tmr != '0) ? step_tmr - CNT_W'(1) : step_tmr;
		next_lines_left = lines_left;
		next_phase_idx = phase_idx;
		next_motor_on = motor_on;
		next_stb_a = 1'b0;
		next_stb_b = 1'b0;
		next_latch = 1'b0;
		sh_req = 1'b0;
		case (state)
			ST_IDLE: begin
				if (start_i && line_count_i != 16'h0) begin
					next_lines_left = line_count_i;
					sh_req = 1'b1;
					next_state = ST_PRELOAD;
				end
			end
			ST_PRELOAD: begin
				next_motor_on = 1'b1;
				next_step_tmr = CNT_W'(FIRST_STEP_CYC_P);
				next_state = ST_START_STEP;
			end
			ST_START_STEP: begin
				// shifting of the first line may overlap the restart phase
				if (step_tmr == '0 && !sh_busy) begin
					next_phase_idx = phase_idx + 2'h1;
					next_step_tmr = CNT_W'(STEP_CYC_P);
					next_latch = 1'b1;
					next_tmr = CNT_W'(LATCH_CYC);
					next_lines_left = lines_left - 16'h1;
					next_state = ST_LATCH;
				end
			end
			ST_LATCH: begin
				next_latch = (tmr > CNT_W'(1));
				if (tmr == '0) begin
					if (lines_left != 16'h0) begin
						sh_req = 1'b1;
					end
					next_tmr = CNT_W'(STROBE_CYC_P);
					next_state = ST_STROBE_A;
				end
			end
			ST_STROBE_A: begin
				if (!inhibit) begin
					next_stb_a = (tmr != '0);
					next_stb_b = (tmr != '0) && !two_division_i;
				end
				if (tmr == '0) begin
					next_tmr = CNT_W'(PAUSE_CYC_P);
					next_state = ST_GAP_A;
				end
			end
			ST_GAP_A: begin
				if (tmr == '0) begin
					if (two_division_i) begin
						next_tmr = CNT_W'(STROBE_CYC_P);
						next_state = ST_STROBE_B;
					end else begin
						next_state = ST_WAIT_STEP;
					end
				end
			end
			ST_STROBE_B: begin
				next_stb_b = (tmr != '0) && !inhibit;
				if (tmr == '0) begin
					next_tmr = CNT_W'(PAUSE_CYC_P);
					next_state = ST_GAP_B;
				end
			end
			ST_GAP_B: begin
				if (tmr == '0) begin
					next_state = ST_WAIT_STEP;
				end
			end
			ST_WAIT_STEP: begin
				if (lines_left == 16'h0) begin
					next_state = ST_FINISH;
				end else if (step_tmr == '0 && !sh_busy) begin
					next_phase_idx = phase_idx + 2'h1;
					next_step_tmr = CNT_W'(STEP_CYC_P);
					next_latch = 1'b1;
					next_tmr = CNT_W'(LATCH_CYC);
					next_lines_left = lines_left - 16'h1;
					next_state = ST_LATCH;
				end
			end
			ST_FINISH: begin
				// keep the phase index so the next restart reuses it
				if (step_tmr == '0) begin
					next_motor_on = 1'b0;
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
			tmr <= '0;
			step_tmr <= '0;
			lines_left <= 16'h0;
			phase_idx <= 2'h0;
			motor_on <= 1'b0;
			stb_a <= 1'b0;
			stb_b <= 1'b0;
			latch <= 1'b0;
		end else begin
			state <= next_state;
			tmr <= next_tmr;
			step_tmr <= next_step_tmr;
			lines_left <= next_lines_left;
			phase_idx <= next_phase_idx;
			motor_on <= next_motor_on;
			stb_a <= next_stb_a;
			stb_b <= next_stb_b;
			latch <= next_latch;
		end
	end

	assign serial_print_bits_o = sdat;
	assign shift_clock_o = sclk;
	assign line_store_o = latch;
	assign strobe_first_division_o = stb_a && !inhibit;
	assign strobe_second_division_o = stb_b && !inhibit;
	assign motor_phase_o = motor_on ? tlps_phase(phase_idx) : PHASE_IDLE;
	assign busy_o = (state != ST_IDLE);
	assign fault_o = inhibit;
endmodule
`default_nettype wire

// [rtl/tlps_pkg.sv]
/*
 package of the thermal line print sequencer: timing constants, motor phase table, states.
 assumes a 100 MHz mclk_i.
*/
package tlps_pkg;
	localparam int CLK_MHZ = 100;
	// pause after every head activation, in microseconds (0.1 ms)
	localparam int PAUSE_US = 100;
	localparam int PAUSE_CYC = PAUSE_US * CLK_MHZ;
	localparam int LINE_BITS = 384;
	localparam int SCLK_DIV = 4;
	localparam int STROBE_CYC = 50000;
	localparam int STEP_CYC = 100000;
	localparam int FIRST_STEP_CYC = 300000;
	localparam int LATCH_CYC = 4;
	localparam int CNT_W = 24;
	localparam int BUF_W = 8;
	localparam logic [3:0] PHASE_IDLE = 4'h0;

	typedef enum logic [3:0] {
		ST_IDLE, ST_PRELOAD, ST_START_STEP, ST_LATCH, ST_STROBE_A, ST_GAP_A,
		ST_STROBE_B, ST_GAP_B, ST_WAIT_STEP, ST_FINISH
	} tlps_state_type;

	// full-step sequence on the four motor lines {a, b, a_n, b_n}
	function automatic logic [3:0] tlps_phase(input logic [1:0] idx);
		case (idx)
			2'h0: tlps_phase = 4'h9;
			2'h1: tlps_phase = 4'hc;
			2'h2: tlps_phase = 4'h6;
			default: tlps_phase = 4'h3;
		endcase
	endfunction
endpackage

// [tb/tb_tlps_ctrl.sv]
/*
 testbench of tlps_ctrl against the head model.
 assumes shortened counts: 16-bit lines.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_tlps_ctrl;
	import tlps_pkg::*;
	typedef struct {int td, n, po, hu, ag, e;} tlps_row_type;
	tlps_row_type rows [6] = '{'{0, 1, 0, 0, 0, 1}, '{1, 2, 0, 0, 0, 2}, '{0, 3, 0, 0, 1, 3},
		'{1, 1, 1, 0, 0, 0}, '{0, 1, 0, 1, 0, 0}, '{0, 0, 0, 0, 0, 0}};
	logic mclk_i = 0, rst_n_i = 0, start_i = 0, two_division_i = 0, data_valid_i = 0;
	logic po = 0, hu = 0, full = 0, pz = 1, have = 0;
	logic [15:0] line_count_i = 16'h0;
	logic [7:0] data_i = 8'h0;
	logic data_ready_o, paper_sense_out_i, head_down_sense_i, serial_print_bits_o, shift_clock_o;
	logic line_store_o, strobe_first_division_o, strobe_second_division_o, busy_o, fault_o;
	logic [3:0] motor_phase_o, last_ph;
	logic [15:0] latch;
	int mismatches = 0, total_checks = 0, idx = 0, lim = 0, n1, n2, nl, k;
	always #5 mclk_i = ~mclk_i;
	tlps_ctrl #(.LINE_BITS_P(16), .STROBE_CYC_P(50), .STEP_CYC_P(200), .FIRST_STEP_CYC_P(300),
		.PAUSE_CYC_P(20)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .start_i(start_i),
		.line_count_i(line_count_i), .two_division_i(two_division_i), .data_valid_i(data_valid_i),
		.data_ready_o(data_ready_o), .data_i(data_i), .paper_sense_out_i(paper_sense_out_i),
		.head_down_sense_i(head_down_sense_i), .serial_print_bits_o(serial_print_bits_o),
		.shift_clock_o(shift_clock_o), .line_store_o(line_store_o),
		.strobe_first_division_o(strobe_first_division_o),
		.strobe_second_division_o(strobe_second_division_o), .motor_phase_o(motor_phase_o),
		.busy_o(busy_o), .fault_o(fault_o));
	tlps_head_model head_u (.bits_i(serial_print_bits_o), .sclk_i(shift_clock_o),
		.lstore_i(line_store_o), .paper_out_i(po), .head_up_i(hu), .ps_o(paper_sense_out_i),
		.hs_o(head_down_sense_i), .latch_o(latch));
	function automatic logic [7:0] pat(input int i);
		pat = 8'(i * 8'h35 + 8'h1b);
	endfunction
	task check(input logic [15:0] got, input logic [15:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task checkb(input logic got, input logic exp, input string m);
		check({15'h0, got}, {15'h0, exp}, m);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// byte feeder, held until taken
	always @(posedge mclk_i) begin
		if (data_valid_i && data_ready_o)
			idx++;
		if (data_valid_i && !data_ready_o)
			full = 1;
		data_valid_i <= idx < lim;
		data_i <= pat(idx);
	end
	always @(posedge strobe_first_division_o) n1++;
	always @(posedge strobe_second_division_o) n2++;
	always @(posedge line_store_o) nl++;
	always @(posedge mclk_i) begin
		if (motor_phase_o !== 4'h0) begin
			if (pz && have)
				check({12'h0, motor_phase_o}, {12'h0, last_ph}, "restart phase");
			last_ph = motor_phase_o;
			have = 1;
			pz = 0;
		end else
			pz = 1;
	end
	task run(input tlps_row_type r);
		int b;
		@(posedge mclk_i);
		b = lim;
		n1 = 0;
		n2 = 0;
		nl = 0;
		two_division_i <= r.td[0];
		po <= r.po[0];
		hu <= r.hu[0];
		lim <= lim + 2 * r.n;
		repeat (6) @(posedge mclk_i);
		start_i <= 1;
		line_count_i <= 16'(r.n);
		@(posedge mclk_i);
		start_i <= 0;
		#1 checkb(busy_o, r.n != 0, "busy after start");
		checkb(fault_o, r.po[0] | r.hu[0], "fault flag");
		if (r.ag != 0) begin
			@(posedge mclk_i);
			start_i <= 1;
			line_count_i <= 16'h5;
			@(posedge mclk_i);
			start_i <= 0;
		end
		for (k = 0; k < 5000 && busy_o !== 1'b0; k++) @(posedge mclk_i);
		#1 check(16'(n1), 16'(r.e), "first strobes");
		check(16'(n2), 16'(r.e), "second strobes");
		check(16'(nl), 16'(r.n), "latch pulses");
		checkb(busy_o, 1'b0, "job ended in time");
		if (r.n != 0)
			check(latch, {pat(b + 2 * r.n - 2), pat(b + 2 * r.n - 1)}, "latched line");
		$display("test done lines %0d", r.n);
	endtask
	initial begin
		repeat (20) @(posedge mclk_i);
		rst_n_i <= 1;
		foreach (rows[i]) run(rows[i]);
		checkb(full, 1'b1, "buffer refused");
		@(posedge mclk_i);
		lim <= lim + 4;
		start_i <= 1;
		line_count_i <= 16'h2;
		@(posedge mclk_i);
		start_i <= 0;
		repeat (100) @(posedge mclk_i);
		rst_n_i <= 0;
		repeat (3) @(posedge mclk_i);
		#1 checkb(busy_o, 1'b0, "busy in reset");
		checkb(|{motor_phase_o, strobe_first_division_o, strobe_second_division_o}, 1'b0,
			"outputs in reset");
		$display("test done reset");
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge mclk_i);
		mismatches++;
		$display("mismatch at %0t: timeout", $time);
		finish_test();
	end
endmodule
`default_nettype wire

// [tb/tlps_ctrl_checker.sv]
/*
 port checker of the print sequencer.
 assumes a bind into tlps_ctrl, one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tlps_ctrl_checker
	import tlps_pkg::*;
#(
	parameter int STEP_CYC_P = 200,
	parameter int PAUSE_CYC_P = 20,
	parameter int FIRST_STEP_CYC_P = 300
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [15:0] line_count_i,
	input wire logic two_division_i,
	input wire logic busy_o,
	input wire logic fault_o,
	input wire logic serial_print_bits_o,
	input wire logic shift_clock_o,
	input wire logic line_store_o,
	input wire logic strobe_first_division_o,
	input wire logic strobe_second_division_o,
	input wire logic [3:0] motor_phase_o
);
	wire s1 = strobe_first_division_o;
	wire s2 = strobe_second_division_o;
	logic [15:0] gap;
	logic [15:0] hold;
	logic [3:0] ph_q;
	logic first_q;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	// cycles since strobes and since the phase last changed
	always_ff @(posedge mclk_i) begin
		ph_q <= motor_phase_o;
		if (!rst_n_i || s1 || s2)
			gap <= rst_n_i ? 16'h0 : 16'hffff;
		else if (gap != 16'hffff)
			gap <= gap + 16'h1;
		if (!rst_n_i || motor_phase_o != ph_q)
			hold <= 16'h0;
		else if (hold != 16'hffff)
			hold <= hold + 16'h1;
		if (!rst_n_i)
			first_q <= 1'b0;
		else if (motor_phase_o != ph_q)
			first_q <= (ph_q == 4'h0);
	end
	pair_single_a: assert property (!two_division_i |-> s1 == s2)
		else $error("strobes split in single mode");
	no_overlap_a: assert property (two_division_i |-> !(s1 && s2))
		else $error("strobes overlap in two-division mode");
	strobe_inhibit_a: assert property (fault_o |-> !(s1 || s2))
		else $error("strobe while inhibited");
	latch_width_a: assert property ($rose(line_store_o) |-> line_store_o[*4] ##1 !line_store_o)
		else $error("latch pulse width wrong");
	latch_apart_a: assert property (line_store_o |-> !(s1 || s2))
		else $error("latch pulse during strobe");
	pause_len_a: assert property ($rose(s1 || s2) |-> gap >= PAUSE_CYC_P)
		else $error("pause after activation too short");
	motor_held_a: assert property ((s1 || s2) |-> $stable(motor_phase_o))
		else $error("motor stepped during activation");
	step_order_a: assert property (motor_phase_o != ph_q && ph_q != 4'h0 && motor_phase_o != 4'h0
		|-> motor_phase_o == {ph_q[0], ph_q[3:1]} && hold >= STEP_CYC_P - 2)
		else $error("motor step order or time wrong");
	restart_hold_a: assert property (motor_phase_o != ph_q && first_q && motor_phase_o != 4'h0
		|-> hold >= FIRST_STEP_CYC_P - 2)
		else $error("restart phase held too short");
	motor_off_a: assert property (!busy_o |-> motor_phase_o == PHASE_IDLE)
		else $error("motor driven while idle");
	job_start_a: assert property (start_i && !busy_o && line_count_i != 16'h0 |=> busy_o)
		else $error("start not taken");
	shift_data_a: assert property ($rose(shift_clock_o) |-> $stable(serial_print_bits_o))
		else $error("data moved at shift edge");
endmodule
bind tlps_ctrl tlps_ctrl_checker #(.STEP_CYC_P(STEP_CYC_P), .PAUSE_CYC_P(PAUSE_CYC_P),
	.FIRST_STEP_CYC_P(FIRST_STEP_CYC_P)) chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.start_i(start_i), .line_count_i(line_count_i), .two_division_i(two_division_i),
	.busy_o(busy_o), .fault_o(fault_o), .serial_print_bits_o(serial_print_bits_o),
	.shift_clock_o(shift_clock_o), .line_store_o(line_store_o),
	.strobe_first_division_o(strobe_first_division_o),
	.strobe_second_division_o(strobe_second_division_o), .motor_phase_o(motor_phase_o));
`default_nettype wire

// [tb/tlps_head_model.sv]
/*
 model of the thermal head and its sense outputs.
 assumes the bench sets paper and head position.
*/
`timescale 1ns/100ps
`default_nettype none
module tlps_head_model #(
	parameter int N = 16
) (
	input wire logic bits_i,
	input wire logic sclk_i,
	input wire logic lstore_i,
	input wire logic paper_out_i,
	input wire logic head_up_i,
	output logic ps_o,
	output logic hs_o,
	output logic [N-1:0] latch_o
);
	logic [N-1:0] sr = '0;
	initial latch_o = '0;
	always @(posedge sclk_i) sr <= {sr[N-2:0], bits_i};
	always @(posedge lstore_i) latch_o <= sr;
	assign hs_o = head_up_i;
	assign ps_o = paper_out_i;
endmodule
`default_nettype wire
